//--- rtl/cfb_pkg.sv
// Package: encodings, widths and timing for the conditional flag branch unit
package cfb_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int PC_W  = 21;                     // Byte address width
  localparam int OP_W  = 16;                     // Instruction word width
  localparam int OFS_W = 8;                      // Signed offset field width

  // ==========================================================================
  // Opcode fields
  // ==========================================================================
  localparam logic [3:0] OPC_GROUP      = 4'hE;  // Upper nibble, branch group
  localparam logic [3:0] OPC_CARRY_CLR  = 4'h3;  // branch_if_carry_clear
  localparam logic [3:0] OPC_NEG_CLR    = 4'h7;  // branch_if_negative_clear
  localparam int         GRP_MSB        = 15;    // Group field position
  localparam int         SUB_MSB        = 11;    // Sub-opcode field position
  localparam int         OFS_MSB        = 7;     // Offset field position

  // ==========================================================================
  // Address arithmetic and timing
  // ==========================================================================
  localparam logic [PC_W-1:0] PC_STEP    = 21'h000002; // One word in bytes
  localparam logic [PC_W-1:0] PC_RESET   = 21'h000000; // Reset vector
  localparam int              TAKEN_CYC  = 2;          // Taken branch cycles
  localparam int              FALL_CYC   = 1;          // Not-taken cycles

  // ==========================================================================
  // Types
  // ==========================================================================
  // Decoded instruction as handed from the decoder
  typedef struct packed {
    logic            valid;  // Word is an executing instruction
    logic [OP_W-1:0] word;   // Instruction word
    logic [PC_W-1:0] addr;   // Byte address of that word
  } cfb_instr_t;

  // Status flags that a branch may test
  typedef struct packed {
    logic carry;             // Carry flag
    logic negative;          // Negative flag
  } cfb_flags_t;

  // Execution state, one-hot
  typedef enum logic [1:0] {
    ST_EXEC  = 2'h1,         // Normal execute cycle
    ST_FLUSH = 2'h2          // Forced no-operation after a taken branch
  } cfb_state_t;

endpackage

//--- rtl/cfb_target_calc.sv
// Module: branch target adder for relative conditional branches
`timescale 1ns/1ps
module cfb_target_calc
  import cfb_pkg::*;
(
  // Operands
  input  wire logic [PC_W-1:0]  instr_addr,  // Address of the branch
  input  wire logic [OFS_W-1:0] offset,      // Signed word offset
  // Result
  output logic      [PC_W-1:0]  target       // Computed branch target
);

  // ==========================================================================
  // Arithmetic
  // ==========================================================================
  logic [PC_W-1:0] ofs_bytes;                // Sign-extended, doubled offset

  // Offset counts words, so sign-extend then double
  always_comb begin
    ofs_bytes = {{(PC_W-OFS_W-1){offset[OFS_W-1]}}, offset, 1'b0};
  end

  // Incremented PC plus byte offset; wraps at address width
  always_comb begin
    target = instr_addr + PC_STEP + ofs_bytes;
  end

endmodule

//--- rtl/cfb_branch_unit.sv
// Module: conditional flag branch execution unit
`timescale 1ns/1ps
module cfb_branch_unit
  import cfb_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk,      // Core clock, 100 MHz
  input  wire logic            rstn,         // Async reset, active low
  // From decoder and status
  input  wire cfb_instr_t      instr,        // Instruction in execute
  input  wire cfb_flags_t      flags_in,     // Current status flags
  // To program counter and pipeline
  output logic                 pc_load,      // Load PC with pc_target
  output logic      [PC_W-1:0] pc_target,    // Branch target address
  output logic                 flush,        // Discard prefetched word
  output logic                 stall,        // Execute slot is a no-op
  output logic                 is_branch,    // Executing one of the branches
  output logic                 flags_we      // Flag write enable, always 0
);

  // ==========================================================================
  // Reset synchroniser
  // ==========================================================================
  logic rst_meta_n;                          // First stage, read by second only
  logic rst_n;                               // Released reset for the design

  // Asynchronous assert, two-stage synchronous release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic            hit_carry;                // Carry-clear opcode present
  logic            hit_neg;                  // Negative-clear opcode present
  logic            take;                     // Branch condition satisfied
  logic [PC_W-1:0] target;                   // Adder output
  cfb_state_t      state;                    // Execution state
  cfb_state_t      next_state;               // Next execution state

  // Opcode match; ignored during the flush slot since that word is stale
  always_comb begin
    hit_carry = instr.valid && (state == ST_EXEC)
             && (instr.word[GRP_MSB -: 4] == OPC_GROUP)
             && (instr.word[SUB_MSB -: 4] == OPC_CARRY_CLR);
    hit_neg   = instr.valid && (state == ST_EXEC)
             && (instr.word[GRP_MSB -: 4] == OPC_GROUP)
             && (instr.word[SUB_MSB -: 4] == OPC_NEG_CLR);
  end

  // Take only when the tested flag is clear
  always_comb begin
    take = (hit_carry && !flags_in.carry)
        || (hit_neg   && !flags_in.negative);
  end

  // Target adder
  cfb_target_calc u_target (
    .instr_addr (instr.addr),
    .offset     (instr.word[OFS_MSB -: OFS_W]),
    .target     (target)
  );

  // ==========================================================================
  // State machine
  // ==========================================================================
  // A taken branch spends its second cycle as a no-op in ST_FLUSH
  always_comb begin
    unique case (state)
      ST_EXEC: begin
        next_state = take ? ST_FLUSH : ST_EXEC;
      end
      ST_FLUSH: begin
        next_state = ST_EXEC;
      end
      default: begin
        next_state = ST_EXEC;                // Illegal code recovers
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic            next_pc_load;             // Registered load strobe
  logic [PC_W-1:0] next_pc_target;           // Registered target

  // Capture target at decode; PC writes on the following edge
  always_comb begin
    next_pc_load   = take;
    next_pc_target = take ? target : pc_target;
  end

  // Data outputs from flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load   <= 1'b0;
      pc_target <= PC_RESET;
    end else begin
      pc_load   <= next_pc_load;
      pc_target <= next_pc_target;
    end
  end

  // Handshake-style outputs are combinational
  always_comb begin
    flush     = take;
    stall     = (state == ST_FLUSH);
    is_branch = hit_carry || hit_neg;
    flags_we  = 1'b0;                        // Branches never write flags
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Carry clear and opcode leads to a load next cycle
  property p_carry_take;
    @(posedge sys_clk) disable iff (!rst_n)
      hit_carry && !flags_in.carry |=> pc_load;
  endproperty
  a_carry_take: assert property (p_carry_take)
    else $error("carry-clear branch not taken");

  // Carry set means no load and no flush
  property p_carry_fall;
    @(posedge sys_clk) disable iff (!rst_n)
      hit_carry && flags_in.carry |-> !flush ##1 !pc_load && !stall;
  endproperty
  a_carry_fall: assert property (p_carry_fall)
    else $error("carry-set branch taken");

  // Negative clear branch loads next cycle
  property p_neg_take;
    @(posedge sys_clk) disable iff (!rst_n)
      hit_neg && !flags_in.negative |=> pc_load;
  endproperty
  a_neg_take: assert property (p_neg_take)
    else $error("negative-clear branch not taken");

  // Negative set falls through
  property p_neg_fall;
    @(posedge sys_clk) disable iff (!rst_n)
      hit_neg && flags_in.negative |=> !pc_load;
  endproperty
  a_neg_fall: assert property (p_neg_fall)
    else $error("negative-set branch taken");

  // Target uses doubled sign-extended offset
  property p_target;
    @(posedge sys_clk) disable iff (!rst_n)
      take |=> pc_target == $past(instr.addr) + PC_STEP
        + {{(PC_W-OFS_W-1){$past(instr.word[OFS_MSB])}},
           $past(instr.word[OFS_MSB -: OFS_W]), 1'b0};
  endproperty
  a_target: assert property (p_target)
    else $error("branch target wrong");

  // Taken costs exactly one extra no-op cycle
  property p_two_cycle;
    @(posedge sys_clk) disable iff (!rst_n)
      take |=> stall ##1 !stall;
  endproperty
  a_two_cycle: assert property (p_two_cycle)
    else $error("taken branch not two cycles");

  // Stall only ever follows a taken branch
  property p_stall_cause;
    @(posedge sys_clk) disable iff (!rst_n)
      stall |-> $past(take) && !take;
  endproperty
  a_stall_cause: assert property (p_stall_cause)
    else $error("stall without taken branch");

  // Flags are never written while a branch executes
  property p_no_flags;
    @(posedge sys_clk) disable iff (!rst_n)
      is_branch |-> !flags_we;
  endproperty
  a_no_flags: assert property (p_no_flags)
    else $error("branch wrote status flags");

  // The target load always lands in the no-op slot, never on its own
  property p_load_in_slot;
    @(posedge sys_clk) disable iff (!rst_n)
      pc_load |-> stall;
  endproperty
  a_load_in_slot: assert property (p_load_in_slot)
    else $error("target load outside no-op slot");

  // Load is one pulse; a branch word in the slot after it is ignored, so no second load follows
  property p_load_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
      pc_load |=> !pc_load;
  endproperty
  a_load_pulse: assert property (p_load_pulse)
    else $error("target load held over two cycles");

  // Without a taken branch the held target must not drift
  property p_target_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      !take |=> $stable(pc_target);
  endproperty
  a_target_hold: assert property (p_target_hold)
    else $error("target changed without taken branch");

  // Main scenarios
  c_carry_taken: cover property (@(posedge sys_clk) disable iff (!rst_n)
    hit_carry && !flags_in.carry ##1 stall);
  c_neg_taken: cover property (@(posedge sys_clk) disable iff (!rst_n)
    hit_neg && !flags_in.negative ##1 stall);
  c_fall: cover property (@(posedge sys_clk) disable iff (!rst_n)
    is_branch && !take);
  c_back: cover property (@(posedge sys_clk) disable iff (!rst_n)
    take && instr.word[OFS_MSB]);

endmodule

//--- tb/tb_conditional_flag_branch_unit.sv
// Testbench: self-checking scenarios for the conditional flag branch unit
`timescale 1ns/1ps
module tb_conditional_flag_branch_unit
  import cfb_pkg::*;
;
  // ==========================================================================
  // Compare helper
  // ==========================================================================
  // Case inequality, so an unknown output never passes
`define CHECK(act, exp) \
  begin \
    samples_checked++; \
    if ((act) !== (exp)) begin \
      miscompares++; \
      $display("mismatch t=%0t got %h exp %h", $time, (act), (exp)); \
    end \
  end

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic            sys_clk;          // Core clock
  logic            rstn;             // Reset, active low
  cfb_instr_t      instr;            // Instruction in execute
  cfb_flags_t      flags_in;         // Status flags
  logic            pc_load;          // PC load pulse
  logic [PC_W-1:0] pc_target;        // Branch target
  logic            flush;            // Prefetch discard
  logic            stall;            // No-op slot
  logic            is_branch;        // Branch decoded
  logic            flags_we;         // Flag write enable
  int              miscompares;      // Failed comparisons
  int              samples_checked;  // All comparisons
  logic [PC_W-1:0] last_tgt;         // Target the unit should hold
  logic [7:0]      ofs [4];          // Offset corner cases
  logic [PC_W-1:0] adr [4];          // Addresses, two of them wrap
  logic [PC_W-1:0] tgts [4];         // Hand-worked targets per pair

  // ==========================================================================
  // Device and clock
  // ==========================================================================
  cfb_branch_unit dut (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .instr     (instr),
    .flags_in  (flags_in),
    .pc_load   (pc_load),
    .pc_target (pc_target),
    .flush     (flush),
    .stall     (stall),
    .is_branch (is_branch),
    .flags_we  (flags_we)
  );

  // Free-running 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // Shared execute task
  // ==========================================================================
  // One instruction, then one idle slot; judges both cycles and the cycle after
  // Expected target e is worked out by hand and used only when taken
  task automatic exec(input logic [OP_W-1:0] w, input logic [PC_W-1:0] a,
                      input logic c, input logic n, input logic br,
                      input logic tk, input logic [PC_W-1:0] e);
    @(posedge sys_clk);
    #1;
    instr    = '{valid: 1'b1, word: w, addr: a};
    flags_in = '{carry: c, negative: n};
    #1;
    `CHECK(is_branch, br)
    `CHECK(flush, tk)
    `CHECK(flags_we, 1'b0)
    @(posedge sys_clk);
    #1;
    instr = '0;
    // Fall-through must leave the old target alone
    if (tk) last_tgt = e;
    `CHECK(pc_load, tk)
    `CHECK(stall, tk)
    `CHECK(pc_target, last_tgt)
    @(posedge sys_clk);
    #1;
    `CHECK(pc_load, 1'b0)
    `CHECK(stall, 1'b0)
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Outputs quiet while reset is held
  task automatic test_reset;
    `CHECK(pc_load, 1'b0)
    `CHECK(stall, 1'b0)
    `CHECK(pc_target, PC_RESET)
    $display("test reset done");
  endtask

  // Carry clear branch; other flag set opposite to catch a swap
  task automatic test_carry_clear;
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 4; k++) begin
        exec({OPC_GROUP, OPC_CARRY_CLR, ofs[k]}, adr[k], f[0], ~f[0],
             1'b1, ~f[0], tgts[k]);
      end
    end
    $display("test carry clear done");
  endtask

  // Negative clear branch; carry set opposite to catch a swap
  task automatic test_negative_clear;
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 4; k++) begin
        exec({OPC_GROUP, OPC_NEG_CLR, ofs[k]}, adr[k], ~f[0], f[0],
             1'b1, ~f[0], tgts[k]);
      end
    end
    $display("test negative clear done");
  endtask

  // A branch sitting in the no-op slot must be discarded
  task automatic test_flush_slot;
    exec({OPC_GROUP, OPC_CARRY_CLR, 8'h10}, 21'h000200, 1'b0, 1'b0,
         1'b1, 1'b1, 21'h000222);
    // Backward taken branch, then a stale branch word in its slot
    @(posedge sys_clk);
    #1;
    instr    = '{valid: 1'b1, word: 16'hE7F0, addr: 21'h000200};
    flags_in = '{carry: 1'b0, negative: 1'b0};
    @(posedge sys_clk);
    #1;
    instr = '{valid: 1'b1, word: 16'hE305, addr: 21'h000300};
    #1;
    `CHECK(stall, 1'b1)
    `CHECK(is_branch, 1'b0)
    `CHECK(flush, 1'b0)
    `CHECK(pc_load, 1'b1)
    `CHECK(pc_target, 21'h0001E2)
    @(posedge sys_clk);
    #1;
    instr    = '0;
    last_tgt = 21'h0001E2;
    `CHECK(pc_load, 1'b0)
    `CHECK(pc_target, last_tgt)
    $display("test flush slot done");
  endtask

  // Neighbouring opcodes and a word without valid do nothing
  task automatic test_other_ops;
    exec(16'hE501, 21'h000400, 1'b0, 1'b0, 1'b0, 1'b0,
         21'h000000);
    exec(16'hF301, 21'h000400, 1'b0, 1'b0, 1'b0, 1'b0,
         21'h000000);
    exec(16'h6701, 21'h000400, 1'b0, 1'b0, 1'b0, 1'b0,
         21'h000000);
    @(posedge sys_clk);
    #1;
    instr    = '{valid: 1'b0, word: 16'hE301, addr: 21'h000400};
    flags_in = '0;
    #1;
    `CHECK(is_branch, 1'b0)
    `CHECK(flush, 1'b0)
    @(posedge sys_clk);
    #1;
    instr = '0;
    `CHECK(pc_load, 1'b0)
    `CHECK(stall, 1'b0)
    $display("test other opcodes done");
  endtask

  // Reset in the no-op slot of a taken branch, then a clean restart
  task automatic test_mid_reset;
    @(posedge sys_clk);
    #1;
    instr    = '{valid: 1'b1, word: 16'hE301, addr: 21'h000040};
    flags_in = '0;
    @(posedge sys_clk);
    #1;
    rstn  = 1'b0;
    instr = '0;
    #1;
    `CHECK(pc_load, 1'b0)
    `CHECK(stall, 1'b0)
    `CHECK(pc_target, PC_RESET)
    repeat (2) @(posedge sys_clk);
    #1;
    rstn     = 1'b1;
    last_tgt = PC_RESET;
    // Two synchroniser flops before the core leaves reset
    repeat (3) @(posedge sys_clk);
    exec(16'hE702, 21'h000010, 1'b1, 1'b0, 1'b1, 1'b1,
         21'h000016);
    $display("test mid reset done");
  endtask

  // ==========================================================================
  // Closing and main sequence
  // ==========================================================================
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cuts a hang short; tests need about 1 us
  initial begin
    #20000;
    miscompares++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    rstn            = 1'b0;
    instr           = '0;
    flags_in        = '0;
    miscompares     = 0;
    samples_checked = 0;
    last_tgt        = PC_RESET;
    ofs = '{8'h7F, 8'h80, 8'hFE, 8'h01};
    adr = '{21'h000100, 21'h000800, 21'h000000, 21'h1FFFFE};
    tgts = '{21'h000200, 21'h000702, 21'h1FFFFE, 21'h000002};
    repeat (4) @(posedge sys_clk);
    #1;
    test_reset();
    rstn = 1'b1;
    // Two synchroniser flops before the core leaves reset
    repeat (3) @(posedge sys_clk);
    test_carry_clear();
    test_negative_clear();
    test_flush_slot();
    test_other_ops();
    test_mid_reset();
    stop_test();
  end

endmodule
